// ### src/emi_mux_pkg.sv
// Package with constants and carriers for the multiplexed memory interface
package emi_mux_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CFG_W = 8;
   localparam int MODE_BIT = 4;
   localparam int WIDTH_LSB = 0;
   localparam int WIDTH_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [3:0] STROBE_CYCLES_DEF = 4'h1;

   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] ad_out;
      logic ad_oe;
      logic ale;
      logic rd_n;
      logic wr_n;
   } mem_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ALE_HIGH,
      ST_ALE_LOW,
      ST_STROBE,
      ST_DONE
   } emi_state_t;
endpackage : emi_mux_pkg

// ### src/ext_mem_mux_address_latch_ctrl.sv
// Multiplexed address/data and latch-enable control for external memory
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: Width field sets latch pulse high and low
// RULE2: Config bit 4 selects multiplexed bus mode
// RULE3: Multiplexed: data and low address share pins
// RULE4: Block itself drives latch enable output
// RULE5: First phase: enable high, low address out
// RULE6: External latch transparent high, holds after fall
// RULE7: Enable falling edge starts second phase
// RULE8: Data bus owns shared pins at strobe
// RULE9: Width field ignored in non-multiplexed mode
// RULE10: Non-multiplexed: separate data and address pins
// RULE11: Multiplexed access takes two extra cycles minimum
// RULE12: Latch enable low when idle or non-multiplexed
module ext_mem_mux_address_latch_ctrl #(
   parameter logic [3:0] STROBE_CYCLES = emi_mux_pkg::STROBE_CYCLES_DEF
)(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [emi_mux_pkg::CFG_W-1:0] ext_mem_config_reg,
   input wire logic req_valid,
   output logic req_ready,
   input wire emi_mux_pkg::mem_req_t req,
   output logic done,
   output logic [emi_mux_pkg::DATA_W-1:0] rdata,
   output emi_mux_pkg::mem_pins_t pins,
   output logic [emi_mux_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [emi_mux_pkg::DATA_W-1:0] ad_in,
   input wire logic [emi_mux_pkg::DATA_W-1:0] data_in
);
   emi_mux_pkg::emi_state_t state_reg, state_next;
   logic [emi_mux_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [emi_mux_pkg::CNT_W-1:0] len_reg, len_next;
   emi_mux_pkg::mem_req_t req_reg, req_next;
   logic mux_reg, mux_next;
   emi_mux_pkg::mem_pins_t pins_reg, pins_next;
   logic [emi_mux_pkg::DATA_W-1:0] dout_reg, dout_next;
   logic doe_reg, doe_next;
   logic [emi_mux_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic done_reg, done_next;
   logic [emi_mux_pkg::CNT_W-1:0] ale_len;
   logic [emi_mux_pkg::CNT_W-1:0] strobe_len;
   logic bus_mux_mode_sel;
   logic [emi_mux_pkg::WIDTH_W-1:0] latch_pulse_width_sel;
   logic in_idle;
   logic in_done;
   logic take;
   logic ale_end;
   logic strobe_start;
   logic strobe_end;

   // Mode bit low means multiplexed
   assign bus_mux_mode_sel = ext_mem_config_reg[emi_mux_pkg::MODE_BIT]; // [RULE2]
   assign latch_pulse_width_sel =
      ext_mem_config_reg[emi_mux_pkg::WIDTH_LSB +: emi_mux_pkg::WIDTH_W];
   // Code n gives n+1 cycles high and n+1 low
   assign ale_len = emi_mux_pkg::CNT_W'(latch_pulse_width_sel) + emi_mux_pkg::CNT_ONE; // [RULE1]
   assign strobe_len = STROBE_CYCLES[emi_mux_pkg::CNT_W-1:0];
   assign req_ready = in_idle;

   // Phase decode for the pin drivers; idle, take, strobe end and done also feed the data register group
   assign in_idle = (state_reg == emi_mux_pkg::ST_IDLE);
   assign in_done = (state_reg == emi_mux_pkg::ST_DONE);
   assign take = in_idle && req_valid;
   assign ale_end = (state_reg == emi_mux_pkg::ST_ALE_HIGH)
      && (cnt_reg == emi_mux_pkg::CNT_ONE);
   assign strobe_start = (state_reg == emi_mux_pkg::ST_ALE_LOW)
      && (cnt_reg == emi_mux_pkg::CNT_ONE);
   assign strobe_end = (state_reg == emi_mux_pkg::ST_STROBE)
      && (cnt_reg <= emi_mux_pkg::CNT_ONE);

   // Sequencer: latch phases, strobe, then done
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      len_next = len_reg;
      req_next = req_reg;
      mux_next = mux_reg;
      case (state_reg)
         emi_mux_pkg::ST_IDLE:
         begin
            if (req_valid)
            begin
               // Mode and width frozen here; later config changes wait
               req_next = req;
               mux_next = ~bus_mux_mode_sel; // [RULE2]
               len_next = ale_len; // [RULE1]
               if (!bus_mux_mode_sel)
               begin
                  cnt_next = ale_len; // [RULE9]
                  state_next = emi_mux_pkg::ST_ALE_HIGH;
               end
               else
               begin
                  cnt_next = strobe_len;
                  state_next = emi_mux_pkg::ST_STROBE;
               end
            end
         end
         emi_mux_pkg::ST_ALE_HIGH:
         begin
            if (cnt_reg == emi_mux_pkg::CNT_ONE)
            begin
               // Low phase as long as the high phase
               cnt_next = len_reg; // [RULE1] [RULE11]
               state_next = emi_mux_pkg::ST_ALE_LOW;
            end
            else
               cnt_next = cnt_reg - emi_mux_pkg::CNT_ONE;
         end
         emi_mux_pkg::ST_ALE_LOW:
         begin
            if (cnt_reg == emi_mux_pkg::CNT_ONE)
            begin
               // Strobe follows the low phase
               cnt_next = strobe_len;
               state_next = emi_mux_pkg::ST_STROBE;
            end
            else
               cnt_next = cnt_reg - emi_mux_pkg::CNT_ONE;
         end
         emi_mux_pkg::ST_STROBE:
         begin
            if (cnt_reg <= emi_mux_pkg::CNT_ONE)
            begin
               state_next = emi_mux_pkg::ST_DONE;
            end
            else
               cnt_next = cnt_reg - emi_mux_pkg::CNT_ONE;
         end
         emi_mux_pkg::ST_DONE:
            state_next = emi_mux_pkg::ST_IDLE;
         default:
            state_next = emi_mux_pkg::ST_IDLE;
      endcase
   end

   // Pin drivers: address phase, latch release, strobe
   always_comb
   begin
      pins_next = pins_reg;
      if (in_idle)
      begin
         pins_next.ale = 1'h0; // [RULE12]
         pins_next.ad_oe = 1'h0;
      end
      if (take)
      begin
         pins_next.addr = req.addr;
         if (!bus_mux_mode_sel)
         begin
            // Low address on shared pins with enable high
            pins_next.ale = 1'h1; // [RULE4] [RULE5]
            pins_next.ad_out = req.addr[emi_mux_pkg::DATA_W-1:0]; // [RULE3]
            pins_next.ad_oe = 1'h1;
         end
         else
         begin
            // Separate pins, no latch phase
            pins_next.ale = 1'h0; // [RULE12]
            pins_next.rd_n = ~req.rd;
            pins_next.wr_n = req.rd;
         end
      end
      if (ale_end)
      begin
         // Falling enable opens second phase; latch holds address
         pins_next.ale = 1'h0; // [RULE7]
         pins_next.ad_oe = 1'h0;
      end
      if (strobe_start)
      begin
         // Data bus takes shared pins with the strobe
         pins_next.ad_out = req_reg.wdata; // [RULE8]
         pins_next.ad_oe = ~req_reg.rd;
         pins_next.rd_n = ~req_reg.rd;
         pins_next.wr_n = req_reg.rd;
      end
      if (strobe_end)
      begin
         pins_next.rd_n = 1'h1;
         pins_next.wr_n = 1'h1;
      end
      if (in_done)
         pins_next.ad_oe = 1'h0;
   end

   // Separate data bus, read capture and completion pulse
   always_comb
   begin
      dout_next = dout_reg;
      doe_next = doe_reg;
      rdata_next = rdata_reg;
      done_next = 1'h0;
      if (in_idle)
         doe_next = 1'h0;
      if (take && bus_mux_mode_sel)
      begin
         dout_next = req.wdata; // [RULE10]
         doe_next = ~req.rd;
      end
      if (strobe_end)
         rdata_next = mux_reg ? ad_in : data_in;
      if (in_done)
      begin
         doe_next = 1'h0;
         done_next = 1'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= emi_mux_pkg::ST_IDLE;
         cnt_reg <= emi_mux_pkg::CNT_ZERO;
         len_reg <= emi_mux_pkg::CNT_ZERO;
         req_reg <= '0;
         mux_reg <= 1'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         len_reg <= len_next;
         req_reg <= req_next;
         mux_reg <= mux_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pins_reg <= '{addr: '0, ad_out: '0, ad_oe: 1'h0, ale: 1'h0, rd_n: 1'h1, wr_n: 1'h1};
      else
         pins_reg <= pins_next;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         dout_reg <= '0;
         doe_reg <= 1'h0;
         rdata_reg <= '0;
         done_reg <= 1'h0;
      end
      else
      begin
         dout_reg <= dout_next;
         doe_reg <= doe_next;
         rdata_reg <= rdata_next;
         done_reg <= done_next;
      end
   end

   assign pins = pins_reg;
   assign data_out = dout_reg;
   assign data_oe = doe_reg;
   assign rdata = rdata_reg;
   assign done = done_reg;
endmodule : ext_mem_mux_address_latch_ctrl

`default_nettype wire

// ### verif/emi_mux_monitor.sv
// Protocol checker for the multiplexed memory interface
`timescale 1ns/100ps
`default_nettype none
module emi_mux_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] ext_mem_config_reg,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire emi_mux_pkg::mem_req_t req,
   input wire logic done,
   input wire emi_mux_pkg::mem_pins_t pins,
   input wire logic data_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire logic tk = req_valid && req_ready;
   wire logic mx = tk && !ext_mem_config_reg[4];
   wire logic [1:0] w = ext_mem_config_reg[1:0];
   idle_ale_a: assert property (req_ready |-> !pins.ale)
      else $error("ale while idle");
   addr_phase_a: assert property (mx |=> pins.ale && pins.ad_oe
      && pins.ad_out == $past(req.addr[7:0])) else $error("bad address phase");
   short_pulse_a: assert property (mx && w == 2'h0 |=> pins.ale ##1 !pins.ale
      ##1 !(pins.rd_n && pins.wr_n)) else $error("bad short pulse");
   long_pulse_a: assert property (mx && w == 2'h3 |=> pins.ale [*4] ##1 !pins.ale [*4])
      else $error("bad long pulse");
   mux_extra_a: assert property (mx |=> !done [*4])
      else $error("mux access too short");
   mux_done_a: assert property (mx |-> ##[5:11] done)
      else $error("mux access too long");
   plain_access_a: assert property (tk && ext_mem_config_reg[4] |=> !pins.ale [*2] ##1 done)
      else $error("bad plain access");
   strobe_quiet_a: assert property (pins.ale |-> pins.rd_n && pins.wr_n)
      else $error("strobe during ale");
   wr_drive_a: assert property (!pins.wr_n |-> pins.ad_oe || data_oe)
      else $error("write data not driven");
   cover property (mx && w == 2'h3);
   cover property (tk && ext_mem_config_reg[4]);
   cover property (done && req_valid);
endmodule : emi_mux_monitor
bind ext_mem_mux_address_latch_ctrl emi_mux_monitor i_mon (.clk_sys, .resetn,
   .ext_mem_config_reg, .req_valid, .req_ready, .req, .done, .pins, .data_oe);
`default_nettype wire

// ### verif/emi_mem_model.sv
// Address latch and byte-wide memory on the far side
`timescale 1ns/100ps
`default_nettype none
module emi_mem_model (
   input wire logic clk_sys,
   input wire logic md,
   input wire emi_mux_pkg::mem_pins_t pins,
   input wire logic [7:0] data_out,
   output logic [7:0] ad_in,
   output logic [7:0] data_in
);
   logic [7:0] mem [256];
   logic [7:0] lat;
   logic [7:0] q = 8'h5a;
   wire logic [7:0] idx = md ? pins.addr[7:0] : lat;
   always_latch if (pins.ale) lat <= pins.ad_out;
   always_ff @(posedge clk_sys) if (!pins.wr_n) mem[idx] <= md ? data_out : pins.ad_out;
   // Released lines toggle
   always_ff @(posedge clk_sys) q <= ~q;
   assign ad_in = pins.rd_n ? q : mem[idx];
   assign data_in = ad_in;
endmodule : emi_mem_model
`default_nettype wire

// ### verif/ext_mem_mux_address_latch_ctrl_tb_top.sv
// Random transfers in both bus modes
`timescale 1ns/100ps
`default_nettype none
module ext_mem_mux_address_latch_ctrl_tb_top;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic [7:0] cfg = 8'h00;
   logic vld = 1'h0;
   logic md = 1'h0;
   emi_mux_pkg::mem_req_t rq = '0;
   logic rdy, done, doe;
   logic [7:0] rdata, dout, adi, di;
   emi_mux_pkg::mem_pins_t pins;
   logic [7:0] shadow [256];
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   ext_mem_mux_address_latch_ctrl i_dut (.clk_sys, .resetn, .ext_mem_config_reg(cfg),
      .req_valid(vld), .req_ready(rdy), .req(rq), .done, .rdata, .pins,
      .data_out(dout), .data_oe(doe), .ad_in(adi), .data_in(di));
   emi_mem_model i_mem (.clk_sys, .md, .pins, .data_out(dout), .ad_in(adi), .data_in(di));
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         results();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Cycles from take to done seen: latch high and low phases, strobe, done
   function automatic logic [7:0] exp_cycles(input logic m, input logic [1:0] w);
      return m ? 8'h02 : 8'(2 * (w + 1) + 2);
   endfunction : exp_cycles
   // Cycles with latch enable high
   function automatic logic [7:0] exp_ale(input logic m, input logic [1:0] w);
      return m ? 8'h00 : 8'(w + 1);
   endfunction : exp_ale
   task automatic xfer(input logic m, input logic [1:0] w, input logic r, input logic [7:0] a);
      int n;
      int h;
      logic [7:0] d;
      n = 0;
      h = 0;
      d = 8'($urandom);
      md = m;
      cfg = {3'h0, m, 2'h0, w};
      rq = '{rd: r, addr: {8'($urandom), a}, wdata: d};
      vld = 1'h1;
      @(posedge clk_sys);
      #1 vld = 1'h0;
      cfg = 8'($urandom);
      chk(8'(rdy), 8'h00);
      do
      begin
         h += int'(pins.ale);
         n++;
         @(posedge clk_sys);
         #1;
      end
      while (done !== 1'h1 && n < 40);
      chk(8'(n), exp_cycles(m, w));
      chk(8'(h), exp_ale(m, w));
      chk(8'(rdy), 8'h01);
      chk(pins.addr[15:8], rq.addr[15:8]);
      chk(pins.addr[7:0], a);
      if (r)
         chk(rdata, shadow[a]);
      else
         shadow[a] = d;
   endtask : xfer
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   initial
   begin
      logic [7:0] a;
      void'($urandom(16628));
      repeat (6) @(posedge clk_sys);
      #1 resetn = 1'h1;
      // Corner: widest pulse, top address, mode swap between write and read
      xfer(1'h0, 2'h3, 1'h0, 8'hff);
      xfer(1'h1, 2'h0, 1'h1, 8'hff);
      for (int i = 0; i < 32; i++)
      begin
         a = 8'($urandom);
         xfer(i[2], i[1:0], 1'h0, a);
         xfer(i[3], 2'($urandom), 1'h1, a);
      end
      results();
   end
endmodule : ext_mem_mux_address_latch_ctrl_tb_top
`default_nettype wire
